// ==== hdl/fcd_pkg.sv ====
// Shared constants and types of the five-channel DMA controller
package fcd_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int          NCH        = 5;
  localparam logic [3:0]  CFG_BYTES  = 4'h8;   // Descriptor bytes per channel
  localparam logic [15:0] CFG_STRIDE = 16'h0008;

  // ----------------------------------------------------------------
  // APB register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ARM  = 8'h00;
  localparam logic [7:0] OFS_REQ  = 8'h04;
  localparam logic [7:0] OFS_FLAG = 8'h08;
  localparam logic [7:0] OFS_CFG0 = 8'h0c;
  localparam logic [7:0] OFS_CFG1 = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;

  localparam int          ARM_ABORT_BIT = 7;
  localparam logic [15:0] RST_CFG_BASE  = 16'h0000;
  localparam logic [4:0]  RST_CH_BITS   = 5'h00;

  // ----------------------------------------------------------------
  // Descriptor field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] STEP_NONE = 2'h0;
  localparam logic [1:0] STEP_INC1 = 2'h1;
  localparam logic [1:0] STEP_INC2 = 2'h2;
  localparam logic [1:0] STEP_DEC1 = 2'h3;

  localparam logic [1:0] MODE_SINGLE  = 2'h0;
  localparam logic [1:0] MODE_BLOCK   = 2'h1;
  localparam logic [1:0] MODE_RSINGLE = 2'h2;
  localparam logic [1:0] MODE_RBLOCK  = 2'h3;

  localparam logic [1:0] PRIO_LOW  = 2'h0;
  localparam logic [1:0] PRIO_NORM = 2'h1;
  localparam logic [1:0] PRIO_HIGH = 2'h2;

  localparam logic [2:0] VL_FIXED = 3'h0;
  localparam logic [2:0] VL_P1    = 3'h1;
  localparam logic [2:0] VL_EXACT = 3'h2;
  localparam logic [2:0] VL_P2    = 3'h3;
  localparam logic [2:0] VL_P3    = 3'h4;

  localparam logic [4:0] TRIG_NONE = 5'h00;
  localparam logic [4:0] TRIG_PREV = 5'h01;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Descriptor, first memory byte in the top bits
  typedef struct packed {
    logic [15:0] src;
    logic [15:0] dst;
    logic [2:0]  variable_length_option;
    logic [12:0] len;
    logic        word;
    logic [1:0]  mode;
    logic [4:0]  trig;
    logic [1:0]  sinc;
    logic [1:0]  dinc;
    logic        imask;
    logic        m8;
    logic [1:0]  prio;
  } fcd_cfg_t;

  typedef struct packed {
    fcd_cfg_t    cfg;
    logic [15:0] sp;
    logic [15:0] dp;
    logic [12:0] cnt;
    logic [12:0] tot;
  } fcd_chan_t;

  typedef struct packed {
    logic        en;
    logic        we;
    logic        word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } fcd_mem_t;

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_FETCH = 5'b00010,
    S_READ  = 5'b00100,
    S_WAIT  = 5'b01000,
    S_WRITE = 5'b10000
  } fcd_state_e;

  typedef struct packed {
    fcd_state_e                fsm;
    fcd_chan_t [NCH-1:0]       ch;
    logic      [NCH-1:0]       rdy;
    logic      [NCH-1:0]       pend;
    logic      [NCH-1:0]       blk;
    logic      [NCH-1:0]       fpend;
    logic      [NCH-1:0]       swreq;
    logic      [NCH-1:0]       flag;
    logic      [NCH-1:0]       done;
    logic      [NCH-1:0]       held;
    logic      [2:0]           fch;
    logic      [2:0]           cur;
    logic      [2:0]           rr;
    logic      [3:0]           fb;
    logic      [15:0]          dat;
    logic      [15:0]          cfg0;
    logic      [15:0]          cfg1;
    logic                      lost;
  } fcd_st_t;

endpackage : fcd_pkg

// ==== hdl/fcd_arb.sv ====
// Channel arbiter: highest priority level, round-robin among equals
`timescale 1ns/100ps
module fcd_arb (
  input  wire logic [4:0]      req,   // Channels wanting memory
  input  wire logic [4:0][1:0] prio,  // Priority level per channel
  input  wire logic [2:0]      rr,    // Last granted channel
  output logic      [2:0]      sel,   // Chosen channel
  output logic                 any    // Some channel chosen
);
  import fcd_pkg::*;

  always_comb
  begin
    logic [1:0] best;
    logic [3:0] idx;
    best = PRIO_LOW;
    idx  = 4'h0;
    sel  = 3'h0;
    any  = 1'b0;
    for (int i = 0; i < NCH; i++)
    begin
      if (req[i] && prio[i] > best)
        best = prio[i];
    end
    for (int k = 1; k <= NCH; k++)
    begin
      idx = {1'b0, rr} + 4'(k);
      if (idx >= 4'(NCH))
        idx = idx - 4'(NCH);
      if (!any && req[idx[2:0]] && prio[idx[2:0]] == best)
      begin
        sel = idx[2:0];
        any = 1'b1;
      end
    end
  end

endmodule : fcd_arb

// ==== hdl/fcd_dma.sv ====
// Five-channel DMA controller with APB register access
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps

// Behaviour
// - Five independent channels 0 to 4 copy data within the data space.
// - A channel transfers nothing until configured and armed by software.
// - Arming one channel loads its descriptor in 9 clocks; early trigger events dropped, early software requests kept.
// - Several armed channels load one after another, channel 1 first, 0 last.
// - Trigger chosen from 31 sources by the loaded descriptor.
// - A software request starts a transfer like the selected trigger.
// - A trigger starts one transfer or a whole block, per mode.
// - Source and destination pointers start from descriptor addresses.
// - After the set count the channel rearms or disarms and interrupts.
// - Variable length taken from first byte, or word bits 12:0.
// - Configured count caps the variable length.
// - Length options: plus one, exact, plus two, plus three units.
// - Seven or eight length bits in byte mode; ignored in word mode.
// - Each channel moves bytes or 16-bit words.
// - Source and destination steps are set independently.
// - A mask bit gates each channel's completion interrupt.
// - Three priority levels arbitrate channels and CPU accesses.
// - Steps are none, plus one, plus two, minus one.
// - Single and block disarm at completion; repeated variants rearm.
// - High beats CPU, normal every second try, low yields; round-robin ties.
// - Completion flag sets regardless of the mask bit.
module fcd_dma (
  input  wire logic             pclk,       // System clock
  input  wire logic             presetn,    // Asynchronous reset, active low
  input  wire logic [7:0]       paddr,      // APB address
  input  wire logic             psel,       // APB select
  input  wire logic             penable,    // APB access phase
  input  wire logic             pwrite,     // APB write
  input  wire logic [31:0]      pwdata,     // APB write data
  output logic      [31:0]      prdata,     // APB read data
  output logic                  pready,     // APB ready
  output logic                  pslverr,    // APB error on unmapped address
  input  wire logic [31:0]      trig_evt,   // Event sources, pulse per event
  input  wire logic             cpu_req,    // CPU wants the memory this cycle
  output logic                  cpu_stall,  // CPU access deferred this cycle
  output fcd_pkg::fcd_mem_t     mem,        // Memory access request
  input  wire logic [15:0]      mem_rdata,  // Read data, cycle after request
  output logic                  dma_irq     // Completion interrupt to CPU
);
  import fcd_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] fcd_step(logic [15:0] a, logic [1:0] s);
    case (s)
      STEP_INC1: return a + 16'h0001;
      STEP_INC2: return a + 16'h0002;
      STEP_DEC1: return a - 16'h0001;
      default:   return a;
    endcase
  endfunction : fcd_step

  function automatic logic fcd_hit(logic [7:0] a);
    return a == OFS_ARM || a == OFS_REQ || a == OFS_FLAG ||
           a == OFS_CFG0 || a == OFS_CFG1 || a == OFS_STAT;
  endfunction : fcd_hit

  function automatic logic [2:0] fcd_first(logic [4:0] m);
    if (m[1]) return 3'h1;
    if (m[2]) return 3'h2;
    if (m[3]) return 3'h3;
    if (m[4]) return 3'h4;
    return 3'h0;
  endfunction : fcd_first

  fcd_st_t          q;
  fcd_st_t          d;
  logic             wr;
  logic             win;
  logic             dma_req;
  logic             last;
  logic [1:0]       cprio;
  logic [4:0]       hit;
  logic [4:0]       elig;
  logic [4:0][1:0]  prio_v;
  logic [4:0]       mask_v;
  logic [2:0]       asel;
  logic             aany;
  fcd_cfg_t         cc;

  assign cc      = q.ch[q.cur].cfg;
  assign wr      = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !fcd_hit(paddr);
  assign dma_req = q.fsm == S_READ || q.fsm == S_WRITE;
  assign cprio   = cc.prio;
  assign last    = ({1'b0, q.ch[q.cur].cnt} + 14'h1) >= {1'b0, q.ch[q.cur].tot};

  // ----------------------------------------------------------------
  // CPU against channel arbitration
  // ----------------------------------------------------------------
  assign win = !cpu_req || cprio >= PRIO_HIGH ||
               (cprio == PRIO_NORM && q.lost);
  assign cpu_stall = cpu_req && ((q.fsm == S_FETCH && q.fb < CFG_BYTES) ||
                                 (dma_req && win));

  // ----------------------------------------------------------------
  // Trigger detection per channel
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    localparam int PREV = (i + NCH - 1) % NCH;
    logic ev;
    assign ev = q.ch[i].cfg.trig == TRIG_NONE ? 1'b0 :
                q.ch[i].cfg.trig == TRIG_PREV ? q.done[PREV] :
                trig_evt[q.ch[i].cfg.trig];
    assign hit[i]    = q.rdy[i] && (ev || q.swreq[i]);
    assign elig[i]   = q.rdy[i] && (q.pend[i] || q.blk[i]);
    assign prio_v[i] = q.ch[i].cfg.prio;
    assign mask_v[i] = q.ch[i].cfg.imask;
  end

  fcd_arb u_arb (
    .req  (elig),
    .prio (prio_v),
    .rr   (q.rr),
    .sel  (asel),
    .any  (aany)
  );

  // ----------------------------------------------------------------
  // Memory port and register read
  // ----------------------------------------------------------------
  always_comb
  begin
    mem       = '0;
    mem.word  = cc.word;
    if (q.fsm == S_FETCH && q.fb < CFG_BYTES)
    begin
      mem.en   = 1'b1;
      mem.word = 1'b0;
      mem.addr = (q.fch == 3'h0 ? q.cfg0 :
                  q.cfg1 + CFG_STRIDE * 16'(q.fch - 3'h1)) + 16'(q.fb);
    end
    else if (q.fsm == S_READ)
    begin
      mem.en   = win;
      mem.addr = q.ch[q.cur].sp;
    end
    else if (q.fsm == S_WRITE)
    begin
      mem.en    = win;
      mem.we    = 1'b1;
      mem.addr  = q.ch[q.cur].dp;
      mem.wdata = q.dat;
    end
  end

  always_comb
  begin
    prdata = 32'h0000_0000;
    case (paddr)
      OFS_ARM:  prdata = {27'h0, q.rdy | q.fpend | q.held |
                          (q.fsm == S_FETCH ? 5'(5'h1 << q.fch) : 5'h00)};
      OFS_REQ:  prdata = {27'h0, q.swreq};
      OFS_FLAG: prdata = {27'h0, q.flag};
      OFS_CFG0: prdata = {16'h0, q.cfg0};
      OFS_CFG1: prdata = {16'h0, q.cfg1};
      OFS_STAT: prdata = {19'h0, q.cur, q.fsm, q.pend};
      default:  prdata = 32'h0000_0000;
    endcase
  end

  assign dma_irq = |(q.flag & mask_v);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    fcd_cfg_t    ncfg;
    logic [12:0] lv;
    logic [13:0] sum;
    ncfg    = q.ch[q.fch].cfg;
    lv      = 13'h0;
    sum     = 14'h0;
    d       = q;
    d.done  = RST_CH_BITS;
    d.pend  = q.pend | hit;
    d.swreq = q.swreq & ~q.rdy;
    if (wr && paddr == OFS_FLAG)
      d.flag = q.flag & ~pwdata[4:0];
    if (wr && paddr == OFS_REQ)
      d.swreq = d.swreq | pwdata[4:0];
    if (wr && paddr == OFS_CFG0)
      d.cfg0 = pwdata[15:0];
    if (wr && paddr == OFS_CFG1)
      d.cfg1 = pwdata[15:0];
    if (wr && paddr == OFS_ARM && !pwdata[ARM_ABORT_BIT])
      d.fpend = q.fpend | (pwdata[4:0] & ~(q.rdy | q.held));
    // Loaded channels turn ready one per clock during the last queued load
    if (|q.held && (q.fsm != S_FETCH || (q.fpend == 5'h00 && q.fb != 4'h0)))
    begin
      d.rdy[fcd_first(q.held)]  = 1'b1;
      d.held[fcd_first(q.held)] = 1'b0;
    end
    unique case (q.fsm)
      S_IDLE:
      begin
        if (|q.fpend)
        begin
          d.fch                   = fcd_first(q.fpend);
          d.fpend[fcd_first(q.fpend)] = 1'b0;
          d.fb                    = 4'h0;
          d.fsm                   = S_FETCH;
        end
        else if (aany)
        begin
          d.cur = asel;
          d.rr  = asel;
          d.blk[asel]  = q.ch[asel].cfg.mode == MODE_BLOCK ||
                         q.ch[asel].cfg.mode == MODE_RBLOCK;
          d.pend[asel] = hit[asel];
          d.fsm = S_READ;
        end
      end
      S_FETCH:
      begin
        ncfg = fcd_cfg_t'({q.ch[q.fch].cfg[55:0], mem_rdata[7:0]});
        if (q.fb != 4'h0)
          d.ch[q.fch].cfg = ncfg;
        if (q.fb == CFG_BYTES)
        begin
          d.ch[q.fch].sp  = ncfg.src;
          d.ch[q.fch].dp  = ncfg.dst;
          d.ch[q.fch].cnt = 13'h0;
          d.ch[q.fch].tot = ncfg.len;
          d.pend[q.fch]   = 1'b0;
          d.blk[q.fch]    = 1'b0;
          // Queued loads run back to back, nine clocks each
          if (|q.fpend)
          begin
            d.held[q.fch]               = 1'b1;
            d.fch                       = fcd_first(q.fpend);
            d.fpend[fcd_first(q.fpend)] = 1'b0;
            d.fb                        = 4'h0;
          end
          else
          begin
            d.rdy[q.fch] = 1'b1;
            d.fsm        = S_IDLE;
          end
        end
        else
          d.fb = q.fb + 4'h1;
      end
      S_READ:
      begin
        d.lost = !win;
        if (!q.rdy[q.cur])
          d.fsm = S_IDLE;
        else if (win)
          d.fsm = S_WAIT;
      end
      S_WAIT:
      begin
        d.dat = cc.word ? mem_rdata : {8'h00, mem_rdata[7:0]};
        lv    = cc.word ? mem_rdata[12:0] :
                cc.m8   ? {5'h00, mem_rdata[7:0]} : {6'h00, mem_rdata[6:0]};
        case (cc.variable_length_option)
          VL_P1:    sum = {1'b0, lv} + 14'h1;
          VL_EXACT: sum = {1'b0, lv};
          VL_P2:    sum = {1'b0, lv} + 14'h2;
          VL_P3:    sum = {1'b0, lv} + 14'h3;
          default:  sum = {1'b0, cc.len};
        endcase
        if (q.ch[q.cur].cnt == 13'h0)
          d.ch[q.cur].tot = sum > {1'b0, cc.len} ? cc.len : sum[12:0];
        d.fsm = S_WRITE;
      end
      S_WRITE:
      begin
        d.lost = !win;
        if (!q.rdy[q.cur])
          d.fsm = S_IDLE;
        else if (win)
        begin
          d.ch[q.cur].sp  = fcd_step(q.ch[q.cur].sp, cc.sinc);
          d.ch[q.cur].dp  = fcd_step(q.ch[q.cur].dp, cc.dinc);
          d.ch[q.cur].cnt = q.ch[q.cur].cnt + 13'h1;
          d.fsm           = S_IDLE;
          if (last)
          begin
            d.flag[q.cur] = 1'b1;
            d.done[q.cur] = 1'b1;
            d.blk[q.cur]  = 1'b0;
            d.pend[q.cur] = hit[q.cur];
            if (cc.mode == MODE_RSINGLE || cc.mode == MODE_RBLOCK)
            begin
              d.ch[q.cur].sp  = cc.src;
              d.ch[q.cur].dp  = cc.dst;
              d.ch[q.cur].cnt = 13'h0;
              d.ch[q.cur].tot = cc.len;
            end
            else
            begin
              d.rdy[q.cur]  = 1'b0;
              d.pend[q.cur] = 1'b0;
            end
          end
        end
      end
    endcase
    if (wr && paddr == OFS_ARM && pwdata[ARM_ABORT_BIT])
    begin
      d.rdy   = d.rdy & ~pwdata[4:0];
      d.pend  = d.pend & ~pwdata[4:0];
      d.blk   = d.blk & ~pwdata[4:0];
      d.fpend = d.fpend & ~pwdata[4:0];
      d.held  = d.held & ~pwdata[4:0];
      if (d.fsm == S_FETCH && pwdata[d.fch])
        d.fsm = S_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q      <= '0;
      q.fsm  <= S_IDLE;
      q.cfg0 <= RST_CFG_BASE;
      q.cfg1 <= RST_CFG_BASE;
    end
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_fetch_nine;
    (q.fsm == S_FETCH && q.fb == 4'h0) |-> ##8 (q.fb == CFG_BYTES) ##1
      (q.rdy[$past(q.fch, 9)] || q.held[$past(q.fch, 9)]);
  endproperty
  a_fetch_nine: assert property (p_fetch_nine) else $error("descriptor load not 9 clocks");

  property p_no_early_pend;
    (q.pend & ~q.rdy) == 5'h00;
  endproperty
  a_no_early_pend: assert property (p_no_early_pend) else $error("pending on unarmed channel");

  property p_armed_only;
    (q.fsm == S_IDLE && d.fsm == S_READ) |=> q.rdy[q.cur];
  endproperty
  a_armed_only: assert property (p_armed_only) else $error("transfer on unarmed channel");

  property p_flag_on_done;
    (q.fsm == S_WRITE && q.rdy[q.cur] && win && last) |=> q.flag[$past(q.cur)];
  endproperty
  a_flag_on_done: assert property (p_flag_on_done) else $error("completion flag missing");

  property p_disarm;
    (q.fsm == S_WRITE && q.rdy[q.cur] && win && last && !cc.mode[1] &&
     !(wr && paddr == OFS_ARM)) |=> !q.rdy[$past(q.cur)];
  endproperty
  a_disarm: assert property (p_disarm) else $error("single or block did not disarm");

  property p_high_wins;
    (q.fsm == S_READ && q.rdy[q.cur] && cprio == PRIO_HIGH) |=> q.fsm == S_WAIT;
  endproperty
  a_high_wins: assert property (p_high_wins) else $error("high priority deferred");

  property p_low_yields;
    (q.fsm == S_READ && q.rdy[q.cur] && cprio == PRIO_LOW && cpu_req) |-> !mem.en ##1
      q.fsm == S_READ;
  endproperty
  a_low_yields: assert property (p_low_yields) else $error("low priority beat CPU");

  property p_norm_second;
    (q.fsm == S_READ && cprio == PRIO_NORM && cpu_req && !win && q.rdy[q.cur]) |=>
      (q.lost && win);
  endproperty
  a_norm_second: assert property (p_norm_second) else $error("normal lost twice");

  property p_count_cap;
    (q.fsm == S_WRITE) |-> q.ch[q.cur].tot <= cc.len;
  endproperty
  a_count_cap: assert property (p_count_cap) else $error("length above count");

  property p_step_after_write;
    (q.fsm == S_WRITE && q.rdy[q.cur] && win && !last && cc.sinc == STEP_INC2) |=>
      q.ch[$past(q.cur)].sp == $past(q.ch[q.cur].sp) + 16'h0002;
  endproperty
  a_step_after_write: assert property (p_step_after_write) else $error("bad source step");

endmodule : fcd_dma

// ==== tb/fcd_mem_mdl.sv ====
// Data memory behind the controller, one cycle read latency
`timescale 1ns/100ps
module fcd_mem_mdl (
  input  wire logic        pclk,       // System clock
  input  fcd_pkg::fcd_mem_t mem,       // Access request from the controller
  output logic [15:0]      mem_rdata   // Read data, cycle after the read
);
  import fcd_pkg::*;
  logic [7:0]  m [0:65535];
  logic        hit_q;
  logic [15:0] rd_q = 16'h0000;

  // ----------------------------------------------------------------
  // Accesses; writes land anywhere, nothing is write-protected
  // ----------------------------------------------------------------
  always @(posedge pclk)
  begin
    hit_q <= mem.en & ~mem.we;
    if (mem.en & mem.we)
    begin
      m[mem.addr] <= mem.word ? mem.wdata[15:8] : mem.wdata[7:0];
      if (mem.word)
        m[16'(mem.addr + 16'h1)] <= mem.wdata[7:0];
    end
    if (mem.en & ~mem.we)
      rd_q <= mem.word ? {m[mem.addr], m[16'(mem.addr + 16'h1)]} : {8'h00, m[mem.addr]};
  end

  // Stale data is shown inverted so it can never pass for a fresh read
  assign mem_rdata = hit_q ? rd_q : ~rd_q;
endmodule : fcd_mem_mdl

// ==== tb/tb_top.sv ====
// Self-checking testbench of the five-channel DMA controller
`timescale 1ns/100ps
module tb_top;
  import fcd_pkg::*;
  typedef struct {
    logic [31:0] cfg;  // Descriptor bytes 4 to 7
    logic [7:0]  fb;   // First source byte
    int          n;    // Units expected
    logic        cpu;  // CPU contends
  } fcd_row_t;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] trig_evt = 32'h0;
  logic        cpu_req = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cpu_stall;
  fcd_mem_t    mem;
  logic [15:0] mem_rdata;
  logic        dma_irq;
  logic [31:0] rd;
  logic        err;
  logic        stall_seen = 1'b0;
  logic [15:0] sa;
  logic [15:0] da;
  logic [7:0]  sh [0:65535];
  int          failures = 0;
  int          checks_done = 0;
  fcd_row_t    rows [9] = '{
    '{32'h0003205a, 8'h00, 3, 1'b1},
    '{32'h0002a0a1, 8'h00, 2, 1'b1},
    '{32'h000320d0, 8'h00, 3, 1'b0},
    '{32'h00022030, 8'h00, 2, 1'b0},
    '{32'h200a2054, 8'h02, 3, 1'b0},
    '{32'h400a2050, 8'h83, 3, 1'b0},
    '{32'h600a2054, 8'h01, 3, 1'b0},
    '{32'h800a2054, 8'h01, 4, 1'b0},
    '{32'h20042054, 8'h09, 4, 1'b0}
  };

  always #50 pclk = ~pclk;
  always @(posedge pclk)
    if (cpu_stall === 1'b1)
      stall_seen <= 1'b1;

  fcd_dma dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
               .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
               .pready(pready), .pslverr(pslverr), .trig_evt(trig_evt),
               .cpu_req(cpu_req), .cpu_stall(cpu_stall), .mem(mem),
               .mem_rdata(mem_rdata), .dma_irq(dma_irq));
  fcd_mem_mdl mdl (.pclk(pclk), .mem(mem), .mem_rdata(mem_rdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    if (failures == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_flag(input int b);
    for (int i = 0; i < 100; i++)
    begin
      apb(1'b0, OFS_FLAG, 32'h0);
      if (rd[b] === 1'b1)
        break;
    end
    check("flag", {31'h0, rd[b]}, 32'h1);
  endtask : wait_flag

  task automatic put_desc(input logic [15:0] b, input logic [63:0] d);
    for (int i = 0; i < 8; i++)
      mdl.m[16'(b + i)] = d[63 - 8 * i -: 8];
  endtask : put_desc

  task automatic pulse;
    @(posedge pclk);
    trig_evt <= 32'h4;
    cpu_req  <= 1'b1;
    @(posedge pclk);
    trig_evt <= 32'h0;
    repeat (4) @(posedge pclk);
    cpu_req  <= 1'b0;
    repeat (26) @(posedge pclk);
  endtask : pulse

  function automatic logic [15:0] stp(input logic [1:0] c);
    return (c == STEP_DEC1) ? 16'hffff : {14'h0, c};
  endfunction : stp

  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_ARM, 32'h0);
    check("arm_rst", rd, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    check("unmapped_rd", rd, 32'h0);
    foreach (rows[r])
    begin
      for (int a = 16'h00f0; a < 16'h0220; a++)
      begin
        mdl.m[a] = (a < 16'h01f0) ? (8'(a) ^ 8'h5a) : 8'h00;
        sh[a] = mdl.m[a];
      end
      mdl.m[16'h0100] = rows[r].fb;
      sh[16'h0100] = rows[r].fb;
      put_desc(16'h0020, {16'h0100, 16'h0200, rows[r].cfg});
      cpu_req <= rows[r].cpu;
      apb(1'b1, OFS_CFG0, 32'h20);
      apb(1'b1, OFS_ARM, 32'h1);
      apb(1'b1, OFS_REQ, 32'h1);
      wait_flag(0);
      check("irq", {31'h0, dma_irq}, {31'h0, rows[r].cfg[3]});
      apb(1'b1, OFS_FLAG, 32'h1);
      apb(1'b0, OFS_ARM, 32'h0);
      check("disarm", {31'h0, rd[0]}, 32'h0);
      cpu_req <= 1'b0;
      sa = 16'h0100;
      da = 16'h0200;
      for (int i = 0; i < rows[r].n; i++)
      begin
        sh[da] = sh[sa];
        if (rows[r].cfg[15])
          sh[16'(da + 16'h1)] = sh[16'(sa + 16'h1)];
        sa = sa + stp(rows[r].cfg[7:6]);
        da = da + stp(rows[r].cfg[5:4]);
      end
      for (int a = 16'h01f0; a < 16'h0220; a++)
        check("dst", {24'h0, mdl.m[a]}, {24'h0, sh[a]});
    end
    check("stall", {31'h0, stall_seen}, 32'h1);
    mdl.m[16'h0100] = 8'h11;
    mdl.m[16'h0101] = 8'h22;
    mdl.m[16'h0200] = 8'h00;
    mdl.m[16'h0201] = 8'h00;
    put_desc(16'h0020, {16'h0100, 16'h0200, 32'h00020250});
    apb(1'b1, OFS_ARM, 32'h1);
    pulse();
    check("early", {24'h0, mdl.m[16'h0200]}, 32'h0);
    pulse();
    check("one", {24'h0, mdl.m[16'h0200]}, 32'h11);
    check("one_only", {24'h0, mdl.m[16'h0201]}, 32'h0);
    pulse();
    wait_flag(0);
    check("two", {24'h0, mdl.m[16'h0201]}, 32'h22);
    apb(1'b1, OFS_FLAG, 32'h1);
    mdl.m[16'h0100] = 8'h33;
    put_desc(16'h0040, {16'h0100, 16'h0200, 32'h00016050});
    apb(1'b1, OFS_CFG1, 32'h40);
    apb(1'b1, OFS_ARM, 32'h2);
    apb(1'b1, OFS_REQ, 32'h2);
    wait_flag(1);
    check("ch1", {24'h0, mdl.m[16'h0200]}, 32'h33);
    apb(1'b0, OFS_ARM, 32'h0);
    check("rearm", {31'h0, rd[1]}, 32'h1);
    apb(1'b1, OFS_ARM, 32'h82);
    apb(1'b0, OFS_ARM, 32'h0);
    check("abort", rd, 32'h0);
    // All five armed at once; channel 2 follows completion of channel 1
    for (int c = 1; c < 4; c++)
      put_desc(16'(16'h0040 + 8 * c),
               {16'h0100, 16'h0200, ((c == 1) ? 32'h00010150 : 32'h00010050)});
    apb(1'b1, OFS_ARM, 32'h1f);
    repeat (41) @(posedge pclk);
    apb(1'b0, OFS_STAT, 32'h0);
    check("load_busy", {27'h0, rd[9:5]}, 32'h2);
    apb(1'b0, OFS_STAT, 32'h0);
    check("load_done", {27'h0, rd[9:5]}, 32'h1);
    apb(1'b1, OFS_REQ, 32'h2);
    wait_flag(2);
    tally_and_finish();
  end
endmodule : tb_top
